// file: txp_pkg.sv
package txp_pkg;
   // ------------------------------------------------------------------
   // Command word layout
   // ------------------------------------------------------------------
   localparam int CMDA_IOC_BIT    = 31;
   localparam int CMDA_ALIGN_HI   = 25;
   localparam int CMDA_ALIGN_LO   = 24;
   localparam int CMDA_OFF_HI     = 20;
   localparam int CMDA_OFF_LO     = 16;
   localparam int CMDA_FIRST_BIT  = 13;
   localparam int CMDA_LAST_BIT   = 12;
   localparam int CMDA_BSZ_HI     = 10;
   localparam int CMDA_BSZ_LO     = 0;
   localparam int CMDB_TAG_HI     = 31;
   localparam int CMDB_TAG_LO     = 16;
   localparam int CMDB_LEN_HI     = 10;
   localparam int CMDB_LEN_LO     = 0;

   localparam logic [1:0] ALIGN_4  = 2'h0;
   localparam logic [1:0] ALIGN_16 = 2'h1;
   localparam logic [1:0] ALIGN_32 = 2'h2;

   // ------------------------------------------------------------------
   // Storage sizes
   // ------------------------------------------------------------------
   localparam int DFIFO_AW = 6;
   localparam int DFIFO_DEPTH = 64;
   localparam int SFIFO_AW = 3;
   localparam int SFIFO_DEPTH = 8;

   // Status word: tag in the upper half, error summary in bit 15.
   localparam int STS_ERR_BIT = 15;

   // ------------------------------------------------------------------
   // Host-side register map (word addresses)
   // ------------------------------------------------------------------
   localparam logic [2:0] HREG_CMD_A  = 3'h0;
   localparam logic [2:0] HREG_CMD_B  = 3'h1;
   localparam logic [2:0] HREG_DATA   = 3'h2;
   localparam logic [2:0] HREG_STATUS = 3'h3;
   localparam logic [2:0] HREG_SPACE  = 3'h4;
   localparam logic [2:0] HREG_FLAGS  = 3'h5;
   localparam logic [2:0] HREG_LEVEL  = 3'h6;

   localparam int FLG_ERR   = 0;
   localparam int FLG_DONE  = 1;
   localparam int FLG_LEVEL = 2;
   localparam int FLG_BUSY  = 3;
   localparam int FLG_REFUS = 4;

   typedef enum logic [1:0] {
      TXP_CMD_A,
      TXP_CMD_B,
      TXP_DATA
   } txp_parse_t;
endpackage

// file: txp_if.sv
`timescale 1ns/1ps
interface txp_if;
   import txp_pkg::*;
   logic                  hw_wr;
   logic [15:0]           hw_data;
   logic [DFIFO_AW:0]     free_words;
   logic [31:0]           sts_data;
   logic [SFIFO_AW:0]     sts_count;
   logic                  sts_pop;
   logic [1:0]            flag_clr;
   logic                  tx_error_flag;
   logic                  tx_buffer_done_flag;
   logic [SFIFO_AW:0]     sts_level;
   logic                  sts_level_hit;

   modport dev (
      input  hw_wr, hw_data, sts_pop, flag_clr, sts_level,
      output free_words, sts_data, sts_count, tx_error_flag,
      output tx_buffer_done_flag, sts_level_hit
   );
   modport host (
      output hw_wr, hw_data, sts_pop, flag_clr, sts_level,
      input  free_words, sts_data, sts_count, tx_error_flag,
      input  tx_buffer_done_flag, sts_level_hit
   );
endinterface

// file: txp_dev.sv
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
// Contract
// - Each buffer opens with two command words.
// - Host writes A, then B, then payload.
// - Packets may span buffers, delimited by command bits.
// - Command B carries free 16-bit tag.
// - Tag copied into packet status word.
// - Differing tags within packet raise error.
// - Differing B words within packet raise error.
// - Received byte count must equal packet length.
// - Start offset drops leading bytes, first 8 words.
// - Each following buffer honours its own offset.
// - Trailing alignment padding accepted then removed.
// - Accept data in whole burst multiples.
// - Completion request raises completion indication.
// - Status word written for every packet attempt; the code drops it when the status FIFO is full.
// - Status level interrupt at programmed count.
// - Host reads free space before writing.
// - Overfilling the data FIFO raises error.
// - Internal words built from ordered 16-bit pairs.
// - Dropped words use no FIFO space.
// - Bit 31 of A sets buffer-done flag.
// - A bits 25:24 select 4/16/32-byte alignment.
// - Host writes zeros to A bits 30:26.
module txp_dev
   import txp_pkg::*;
(
   input  wire logic  clk_sys_i,
   input  wire logic  sys_rst_i,
   input  wire logic  ce_i,
   txp_if.dev         bus,
   output logic [31:0] tx_word_o,
   output logic       tx_valid_o,
   input  wire logic  tx_ready_i
);
   // ------------------------------------------------------------------
   // Half-word assembly
   // ------------------------------------------------------------------
   logic [15:0] half_lo_ff;
   logic        half_have_ff;
   logic        word_v;
   logic [31:0] word;

   assign word_v = ce_i && bus.hw_wr && half_have_ff;
   assign word   = {bus.hw_data, half_lo_ff};

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         half_lo_ff   <= 16'h0000;
         half_have_ff <= 1'b0;
      end else if (ce_i && bus.hw_wr) begin
         half_lo_ff   <= bus.hw_data;
         half_have_ff <= ~half_have_ff;
      end
   end

   // ------------------------------------------------------------------
   // Command parsing and buffer geometry
   // ------------------------------------------------------------------
   txp_parse_t  st_ff;
   logic [31:0] cmda_ff;
   logic [31:0] pkt_b_ff;
   logic        in_pkt_ff;
   logic [10:0] widx_ff;
   logic [10:0] nwords_ff;
   logic [11:0] bytes_ff;
   logic        perr_ff;

   logic [4:0]  off_w;
   logic [11:0] end_b;
   logic [10:0] need_w;
   logic [10:0] amask;
   logic [10:0] nxt_nwords;
   logic [11:0] bsz;
   logic        buf_end;
   logic        is_first;
   logic        b_bad;
   logic        len_bad;
   logic        keep;
   logic [10:0] first_w;
   logic [10:0] last_w;

   assign off_w  = cmda_ff[CMDA_OFF_HI:CMDA_OFF_LO];
   assign bsz    = {1'b0, cmda_ff[CMDA_BSZ_HI:CMDA_BSZ_LO]};
   assign end_b  = bsz + {7'h00, off_w};
   assign need_w = end_b[11:2] + {10'h000, |end_b[1:0]};

   // Round the word count up to the burst boundary the host pads to.
   always_comb begin
      case (cmda_ff[CMDA_ALIGN_HI:CMDA_ALIGN_LO])
         ALIGN_16: amask = 11'h003;
         ALIGN_32: amask = 11'h007;
         default:  amask = 11'h000;
      endcase
   end
   assign nxt_nwords = (need_w + amask) & ~amask;

   assign first_w = {8'h00, off_w[4:2]};
   assign last_w  = need_w - 11'h001;
   // Only words holding payload bytes are stored; offset and padding
   // words are consumed here and never touch the FIFO.
   assign keep = (bsz != 12'h000) && (widx_ff >= first_w) && (widx_ff <= last_w);

   assign is_first = cmda_ff[CMDA_FIRST_BIT] || !in_pkt_ff;
   assign b_bad    = !is_first && (word != pkt_b_ff);

   assign buf_end = (st_ff == TXP_CMD_B && word_v && nxt_nwords == 11'h000) ||
                    (st_ff == TXP_DATA && word_v && widx_ff == nwords_ff - 11'h001);

   logic [31:0] cur_b;
   assign cur_b   = (st_ff == TXP_CMD_B) ? word : pkt_b_ff;
   assign len_bad = (bytes_ff + bsz) != {1'b0, cur_b[CMDB_LEN_HI:CMDB_LEN_LO]};

   logic dfull;
   logic ovf;
   assign ovf = (st_ff == TXP_DATA) && word_v && keep && dfull;

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         st_ff     <= TXP_CMD_A;
         cmda_ff   <= 32'h00000000;
         pkt_b_ff  <= 32'h00000000;
         nwords_ff <= 11'h000;
         widx_ff   <= 11'h000;
      end else if (ce_i && word_v) begin
         case (st_ff)
            TXP_CMD_A: begin
               cmda_ff <= word;
               st_ff   <= TXP_CMD_B;
            end
            TXP_CMD_B: begin
               if (is_first) begin
                  pkt_b_ff <= word;
               end
               nwords_ff <= nxt_nwords;
               widx_ff   <= 11'h000;
               st_ff     <= (nxt_nwords == 11'h000) ? TXP_CMD_A : TXP_DATA;
            end
            TXP_DATA: begin
               widx_ff <= widx_ff + 11'h001;
               if (buf_end) begin
                  st_ff <= TXP_CMD_A;
               end
            end
            default: st_ff <= TXP_CMD_A;
         endcase
      end
   end

   // Packet bookkeeping: byte total and pending error across buffers.
   logic pkt_close;
   assign pkt_close = buf_end && cmda_ff[CMDA_LAST_BIT];

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         in_pkt_ff <= 1'b0;
         bytes_ff  <= 12'h000;
         perr_ff   <= 1'b0;
      end else if (ce_i) begin
         if (pkt_close) begin
            in_pkt_ff <= 1'b0;
            bytes_ff  <= 12'h000;
            perr_ff   <= 1'b0;
         end else begin
            if (st_ff == TXP_CMD_B && word_v && is_first) begin
               perr_ff  <= 1'b0;
               bytes_ff <= 12'h000;
            end else if (st_ff == TXP_CMD_B && word_v && b_bad) begin
               perr_ff <= 1'b1;
            end else if (ovf) begin
               perr_ff <= 1'b1;
            end
            if (buf_end) begin
               in_pkt_ff <= 1'b1;
               bytes_ff  <= bytes_ff + bsz;
            end
         end
      end
   end

   logic pkt_err;
   assign pkt_err = perr_ff || ovf || len_bad ||
                    (st_ff == TXP_CMD_B && b_bad);

   // ------------------------------------------------------------------
   // Transmit data FIFO
   // ------------------------------------------------------------------
   logic [31:0]         dmem [DFIFO_DEPTH];
   logic [DFIFO_AW-1:0] dwp_ff;
   logic [DFIFO_AW-1:0] drp_ff;
   logic [DFIFO_AW:0]   dcnt_ff;
   logic                dpush;
   logic                dpop;

   assign dfull  = dcnt_ff[DFIFO_AW];
   assign dpush  = (st_ff == TXP_DATA) && word_v && keep && !dfull;
   assign dpop   = ce_i && tx_valid_o && tx_ready_i;
   assign tx_valid_o = (dcnt_ff != 7'h00);
   assign tx_word_o  = dmem[drp_ff];
   assign bus.free_words = 7'(DFIFO_DEPTH) - dcnt_ff;

   always_ff @(posedge clk_sys_i) begin
      if (dpush) begin
         dmem[dwp_ff] <= word;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         dwp_ff  <= '0;
         drp_ff  <= '0;
         dcnt_ff <= '0;
      end else if (ce_i) begin
         dwp_ff  <= dwp_ff + DFIFO_AW'(dpush);
         drp_ff  <= drp_ff + DFIFO_AW'(dpop);
         dcnt_ff <= dcnt_ff + 7'(dpush) - 7'(dpop);
      end
   end

   // ------------------------------------------------------------------
   // Status FIFO, one word per packet
   // ------------------------------------------------------------------
   logic [31:0]         smem [SFIFO_DEPTH];
   logic [SFIFO_AW-1:0] swp_ff;
   logic [SFIFO_AW-1:0] srp_ff;
   logic [SFIFO_AW:0]   scnt_ff;
   logic                spush;
   logic                spop;
   logic [31:0]         sword;

   assign sword = {cur_b[CMDB_TAG_HI:CMDB_TAG_LO], pkt_err, 15'h0000};
   // A full status FIFO loses the word; no flag records the loss.
   assign spush = ce_i && pkt_close && (scnt_ff != 4'(SFIFO_DEPTH));
   assign spop  = ce_i && bus.sts_pop && (scnt_ff != 4'h0);
   assign bus.sts_data  = (scnt_ff != 4'h0) ? smem[srp_ff] : 32'h00000000;
   assign bus.sts_count = scnt_ff;

   always_ff @(posedge clk_sys_i) begin
      if (spush) begin
         smem[swp_ff] <= sword;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         swp_ff  <= '0;
         srp_ff  <= '0;
         scnt_ff <= '0;
      end else if (ce_i) begin
         swp_ff  <= swp_ff + SFIFO_AW'(spush);
         srp_ff  <= srp_ff + SFIFO_AW'(spop);
         scnt_ff <= scnt_ff + 4'(spush) - 4'(spop);
      end
   end

   // Level zero disables the status-level indication.
   assign bus.sts_level_hit = (bus.sts_level != 4'h0) && (scnt_ff >= bus.sts_level);

   // ------------------------------------------------------------------
   // Sticky flags; a new event in the clearing cycle wins.
   // ------------------------------------------------------------------
   logic err_ff;
   logic done_ff;
   logic err_set;
   logic done_set;

   assign err_set  = ce_i && ((pkt_close && pkt_err) || ovf ||
                     (st_ff == TXP_CMD_B && word_v && b_bad));
   assign done_set = ce_i && buf_end && cmda_ff[CMDA_IOC_BIT];

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         err_ff <= 1'b0;
      end else if (err_set) begin
         err_ff <= 1'b1;
      end else if (ce_i && bus.flag_clr[FLG_ERR]) begin
         err_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         done_ff <= 1'b0;
      end else if (done_set) begin
         done_ff <= 1'b1;
      end else if (ce_i && bus.flag_clr[FLG_DONE]) begin
         done_ff <= 1'b0;
      end
   end

   assign bus.tx_error_flag       = err_ff;
   assign bus.tx_buffer_done_flag = done_ff;
endmodule

// file: txp_host.sv
`timescale 1ns/1ps
module txp_host
   import txp_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        sys_rst_i,
   input  wire logic        ce_i,
   txp_if.host              bus,
   input  wire logic [2:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic [31:0]      rdata_o
);
   // ------------------------------------------------------------------
   // Word to half-word splitter
   // ------------------------------------------------------------------
   // A 32-bit word leaves as two 16-bit writes, low half first. A word
   // write in the cycle right after another is refused and flagged,
   // because the bus interface must never stall the command port.
   logic [15:0] hi_ff;
   logic        busy_ff;
   logic        hw_wr_ff;
   logic [15:0] hw_data_ff;
   logic        refus_ff;
   logic        word_wr;
   logic        take;
   logic        level_wr;

   assign word_wr = wr_i && (addr_i == HREG_CMD_A || addr_i == HREG_CMD_B ||
                             addr_i == HREG_DATA);
   // Payload with no free space is refused.
   assign take = ce_i && word_wr && !busy_ff &&
                 !(addr_i == HREG_DATA && bus.free_words == 7'h00);

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         hi_ff      <= 16'h0000;
         busy_ff    <= 1'b0;
         hw_wr_ff   <= 1'b0;
         hw_data_ff <= 16'h0000;
      end else if (ce_i) begin
         if (take) begin
            hw_wr_ff   <= 1'b1;
            hw_data_ff <= wdata_i[15:0];
            hi_ff      <= wdata_i[31:16];
            busy_ff    <= 1'b1;
         end else if (busy_ff) begin
            hw_wr_ff   <= 1'b1;
            hw_data_ff <= hi_ff;
            busy_ff    <= 1'b0;
         end else begin
            hw_wr_ff   <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         refus_ff <= 1'b0;
      end else if (ce_i && word_wr && !take) begin
         refus_ff <= 1'b1;
      end else if (ce_i && wr_i && addr_i == HREG_FLAGS && wdata_i[FLG_REFUS]) begin
         refus_ff <= 1'b0;
      end
   end

   assign bus.hw_wr   = hw_wr_ff && ce_i;
   assign bus.hw_data = hw_data_ff;

   // ------------------------------------------------------------------
   // Level, flag clear, status pop
   // ------------------------------------------------------------------
   logic [SFIFO_AW:0] level_ff;
   assign level_wr = ce_i && wr_i && addr_i == HREG_LEVEL;

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         level_ff <= '0;
      end else if (level_wr) begin
         level_ff <= wdata_i[SFIFO_AW:0];
      end
   end

   assign bus.sts_level = level_ff;
   assign bus.sts_pop   = ce_i && rd_i && addr_i == HREG_STATUS;
   assign bus.flag_clr  = (ce_i && wr_i && addr_i == HREG_FLAGS) ?
                          wdata_i[1:0] : 2'h0;

   // ------------------------------------------------------------------
   // Read data, one cycle after the strobe
   // ------------------------------------------------------------------
   logic [31:0] nxt_rdata;
   always_comb begin
      case (addr_i)
         HREG_STATUS: nxt_rdata = bus.sts_data;
         HREG_SPACE:  nxt_rdata = {25'h0000000, bus.free_words};
         HREG_FLAGS:  nxt_rdata = {20'h00000, bus.sts_count, 3'h0, refus_ff,
                                   busy_ff, bus.sts_level_hit,
                                   bus.tx_buffer_done_flag, bus.tx_error_flag};
         HREG_LEVEL:  nxt_rdata = {28'h0000000, level_ff};
         default:     nxt_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         rdata_o <= 32'h00000000;
      end else if (ce_i && rd_i) begin
         rdata_o <= nxt_rdata;
      end else if (ce_i) begin
         rdata_o <= 32'h00000000;
      end
   end
endmodule

// file: txp_link_monitor.sv
`timescale 1ns/1ps
module txp_link_monitor
   import txp_pkg::*;
(
   input wire logic                clk_sys_i,
   input wire logic                sys_rst_i,
   input wire logic                hw_wr,
   input wire logic [15:0]         hw_data,
   input wire logic [DFIFO_AW:0]   free_words,
   input wire logic [31:0]         sts_data,
   input wire logic [SFIFO_AW:0]   sts_count,
   input wire logic                sts_pop,
   input wire logic [1:0]          flag_clr,
   input wire logic                tx_error_flag,
   input wire logic                tx_buffer_done_flag,
   input wire logic [SFIFO_AW:0]   sts_level,
   input wire logic                sts_level_hit
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);

   // Parity of the current run of half-word writes; back-to-back words
   // make one long run, so only an odd run length betrays a lone half.
   logic run_odd_ff;

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         run_odd_ff <= 1'b0;
      end else begin
         run_odd_ff <= hw_wr ? ~run_odd_ff : 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Link checks
   // ---------------------------------------------------------------
   // A word crosses as exactly two halves; a lone half would shift every later word.
   sequence s_word_halves;
      hw_wr ##1 hw_wr;
   endsequence

   a_word_pairing: assert property ($rose(hw_wr) |-> s_word_halves)
      else $error("half-word writes not sent in pairs");
   a_run_even: assert property (!hw_wr |-> !run_odd_ff)
      else $error("half-word run ended on an odd count");
   a_level_hit: assert property (sts_level_hit == (sts_level != '0 && sts_count >= sts_level))
      else $error("status level indication wrong");
   a_err_sticky: assert property (tx_error_flag && !flag_clr[0] |=> tx_error_flag)
      else $error("error flag dropped without clear");
   a_done_sticky: assert property (tx_buffer_done_flag && !flag_clr[1] |=> tx_buffer_done_flag)
      else $error("done flag dropped without clear");
   a_err_cause: assert property ($rose(tx_error_flag) |-> $past(hw_wr))
      else $error("error flag rose without a completed word");
   a_done_cause: assert property ($rose(tx_buffer_done_flag) |-> $past(hw_wr))
      else $error("done flag rose without a completed word");
   a_sts_empty: assert property (sts_count == '0 |-> sts_data == 32'h0)
      else $error("status head not zero when empty");
   a_sts_layout: assert property (sts_data[14:0] == 15'h0)
      else $error("status word low bits not zero");
   a_pop_count: assert property (sts_pop && sts_count != '0 && !hw_wr
                                 |=> sts_count == $past(sts_count) - 4'h1)
      else $error("status pop did not lower the count");
   a_count_cause: assert property (!hw_wr |=> sts_count <= $past(sts_count))
      else $error("status count rose without a word");
   a_free_hold: assert property (!hw_wr |=> free_words >= $past(free_words))
      else $error("free space fell without a word");
endmodule

// file: txp_tb_top.sv
`timescale 1ns/1ps
module txp_tb_top
   import txp_pkg::*;
;
   logic        clk_sys_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        ce        = 1'b1;
   logic [2:0]  cmd_addr  = 3'h0;
   logic [31:0] cmd_wdata = 32'h0;
   logic        cmd_wr    = 1'b0;
   logic        cmd_rd    = 1'b0;
   logic [31:0] cmd_rdata;
   logic [31:0] tx_word;
   logic        tx_valid;
   logic        tx_ready  = 1'b0;
   logic [31:0] rd_val;
   logic [31:0] exp_q[$];
   int          mismatches = 0;
   int          checks     = 0;
   int          cycles     = 0;

   txp_if bus ();
   txp_host u_txp_host (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .bus(bus),
      .addr_i(cmd_addr), .wdata_i(cmd_wdata), .wr_i(cmd_wr), .rd_i(cmd_rd), .rdata_o(cmd_rdata));
   txp_dev u_txp_dev (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .bus(bus),
      .tx_word_o(tx_word), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready));
   txp_link_monitor u_txp_link_monitor (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .hw_wr(bus.hw_wr), .hw_data(bus.hw_data), .free_words(bus.free_words),
      .sts_data(bus.sts_data), .sts_count(bus.sts_count), .sts_pop(bus.sts_pop),
      .flag_clr(bus.flag_clr), .tx_error_flag(bus.tx_error_flag),
      .tx_buffer_done_flag(bus.tx_buffer_done_flag), .sts_level(bus.sts_level),
      .sts_level_hit(bus.sts_level_hit));

   // ---------------------------------------------------------------
   // Bus tasks
   // ---------------------------------------------------------------
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr_word(input logic [2:0] a, input logic [31:0] d);
      logic go;
      // A refused data word never reaches the link, so its halves are not looked for.
      go = (a < HREG_DATA) || (bus.free_words != '0);
      @(posedge clk_sys_i);
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_wr <= 1'b1;
      @(posedge clk_sys_i);
      cmd_wr <= 1'b0;
      if (a <= HREG_DATA && go) begin
         #1;
         cmp({15'h0, bus.hw_wr, bus.hw_data}, {16'h1, d[15:0]});
         @(posedge clk_sys_i);
         #1;
         cmp({15'h0, bus.hw_wr, bus.hw_data}, {16'h1, d[31:16]});
      end
   endtask

   task automatic rd_reg(input logic [2:0] a);
      @(posedge clk_sys_i);
      cmd_addr <= a;
      cmd_rd <= 1'b1;
      @(posedge clk_sys_i);
      cmd_rd <= 1'b0;
      #1;
      rd_val = cmd_rdata;
   endtask

   task automatic chk_flags(input logic [11:0] e);
      rd_reg(HREG_FLAGS);
      cmp({20'h0, rd_val[11:0]}, {20'h0, e});
   endtask

   function automatic logic [31:0] mk_a(input logic ioc, input logic [1:0] al,
         input logic [4:0] off, input logic fs, input logic ls, input logic [10:0] sz);
      return {ioc, 5'h0, al, 3'h0, off, 2'h0, fs, ls, 1'b0, sz};
   endfunction

   function automatic logic [31:0] mk_b(input logic [15:0] tag, input logic [10:0] len);
      return {tag, 5'h0, len};
   endfunction

   task automatic send_buf(input logic [31:0] a, input logic [31:0] b, input logic [31:0] base);
      int off, sz, n, unit;
      off = int'(a[20:16]);
      sz = int'(a[10:0]);
      unit = (a[25:24] == ALIGN_32) ? 8 : (a[25:24] == ALIGN_16) ? 4 : 1;
      n = (off + sz + 3) / 4;
      n = ((n + unit - 1) / unit) * unit;
      wr_word(HREG_CMD_A, a);
      wr_word(HREG_CMD_B, b);
      for (int i = 0; i < n; i++) begin
         wr_word(HREG_DATA, base + i);
         if (sz > 0 && i >= off / 4 && i <= (off + sz - 1) / 4) exp_q.push_back(base + i);
      end
   endtask

   task automatic drain();
      while (exp_q.size() > 0) begin
         cmp({31'h0, tx_valid}, 32'h1);
         cmp(tx_word, exp_q.pop_front());
         @(posedge clk_sys_i);
         tx_ready <= 1'b1;
         @(posedge clk_sys_i);
         tx_ready <= 1'b0;
         #1;
      end
      cmp({31'h0, tx_valid}, 32'h0);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_single();
      wr_word(HREG_LEVEL, 32'h1);
      send_buf(mk_a(1'b1, ALIGN_16, 5'h5, 1'b1, 1'b1, 11'hA), mk_b(16'hA5C3, 11'hA), 32'h11000000);
      rd_reg(HREG_SPACE);
      cmp({25'h0, rd_val[6:0]}, 32'h3D);
      chk_flags(12'h106);
      rd_reg(HREG_STATUS);
      cmp(rd_val, 32'hA5C30000);
      chk_flags(12'h002);
      wr_word(HREG_FLAGS, 32'h13);
      chk_flags(12'h000);
      drain();
   endtask

   task automatic t_multi();
      send_buf(mk_a(1'b0, ALIGN_32, 5'h0, 1'b1, 1'b0, 11'h6), mk_b(16'h0001, 11'hA), 32'h22000000);
      chk_flags(12'h000);
      send_buf(mk_a(1'b0, ALIGN_4, 5'h3, 1'b0, 1'b1, 11'h4), mk_b(16'h0001, 11'hA), 32'h23000000);
      chk_flags(12'h104);
      rd_reg(HREG_STATUS);
      cmp(rd_val, 32'h00010000);
      drain();
   endtask

   task automatic t_errors();
      for (int k = 0; k < 3; k++) begin
         if (k < 2) begin
            send_buf(mk_a(1'b0, ALIGN_4, 5'h0, 1'b1, 1'b0, 11'h4), mk_b(16'h0010, 11'h8),
                     32'h30000000);
            send_buf(mk_a(1'b0, ALIGN_4, 5'h0, 1'b0, 1'b1, 11'h4),
                     mk_b(16'h0010 + 16'(k == 0), 11'h8 + 11'(k == 1)), 32'h31000000);
         end else begin
            send_buf(mk_a(1'b0, ALIGN_4, 5'h0, 1'b1, 1'b1, 11'h4), mk_b(16'h0012, 11'h5),
                     32'h32000000);
         end
         chk_flags(12'h105);
         rd_reg(HREG_STATUS);
         cmp({16'h0, rd_val[15:0]}, 32'h8000);
         wr_word(HREG_FLAGS, 32'h13);
         drain();
      end
   endtask

   task automatic t_overfill();
      wr_word(HREG_CMD_A, mk_a(1'b0, ALIGN_4, 5'h0, 1'b1, 1'b1, 11'h120));
      wr_word(HREG_CMD_B, mk_b(16'h0020, 11'h120));
      // Words two cycles apart see a free count that lags by one word, so
      // the 65th word reaches the full FIFO and the later ones are refused.
      for (int i = 0; i < 72; i++) begin
         @(posedge clk_sys_i);
         cmd_addr  <= HREG_DATA;
         cmd_wdata <= 32'h40000000 + i;
         cmd_wr    <= 1'b1;
         @(posedge clk_sys_i);
         cmd_wr    <= 1'b0;
      end
      rd_reg(HREG_SPACE);
      cmp({25'h0, rd_val[6:0]}, 32'h0);
      rd_reg(HREG_FLAGS);
      cmp({31'h0, rd_val[FLG_REFUS]}, 32'h1);
      cmp({31'h0, rd_val[FLG_ERR]}, 32'h1);
      @(posedge clk_sys_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      rd_reg(HREG_SPACE);
      cmp({25'h0, rd_val[6:0]}, 32'h40);
      cmp({31'h0, tx_valid}, 32'h0);
   endtask

   task automatic t_freeze();
      send_buf(mk_a(1'b1, ALIGN_4, 5'h0, 1'b1, 1'b1, 11'h4), mk_b(16'h0040, 11'h4),
               32'h50000000);
      // With the clock enable low, a ready drain must not pop anything.
      @(posedge clk_sys_i);
      ce       <= 1'b0;
      tx_ready <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      ce       <= 1'b1;
      tx_ready <= 1'b0;
      chk_flags(12'h102);
      rd_reg(HREG_STATUS);
      cmp(rd_val, 32'h00400000);
      drain();
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   // The whole run needs a few hundred cycles; the ceiling leaves ample margin.
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         print_verdict();
      end
   end

   initial begin
      repeat (5) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      t_single();
      t_multi();
      t_errors();
      t_overfill();
      t_freeze();
      print_verdict();
   end
endmodule
